// ### hdl/ccg_clock_ctrl.sv
// Purpose: stop / start of cpu, half-duty and peripheral clocks, slow / fast control of the cpu and half-duty clocks
// Assumes: clk is the selected source (oscillator or external frequency), all pins asynchronous
// Notes:   clocks are produced as registered levels, one source pulse per clk edge
`timescale 1ns/100ps
`default_nettype none

module ccg_clock_ctrl
    import ccg_pkg::*;
#(
    parameter int unsigned WARM_CYCLES = WARMUP_PULSES,       // crystal restart delay
    parameter int unsigned SLOW_PULSES = SLOW_FILTER_PULSES,  // slow request filter
    parameter int unsigned FAST_PULSES = FAST_FILTER_PULSES   // fast request filter
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // processor status / stop command pins
    input  wire logic status_bit_zero,
    input  wire logic status_bit_one,
    input  wire logic stop_status_line,
    // speed and restart pins
    input  wire logic speed_select,
    input  wire logic start,
    input  wire logic reset_input_n,
    // source strap: high selects external frequency, low crystal
    input  wire logic source_select,
    // generated clocks
    output logic      cpu_clock,
    output logic      half_duty_clock,
    output logic      peripheral_clock,
    // oscillator and source control
    output logic      oscillator_run,
    output logic      source_gated,
    // status
    output logic      clocks_stopped,
    output logic      fast_mode
);

    // -------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------
    if (WARM_CYCLES < 1 || WARM_CYCLES > 65535) begin : g_bad_warm
        $error("ccg_clock_ctrl: WARM_CYCLES out of range");
    end
    if (SLOW_PULSES < 1 || FAST_PULSES < 1) begin : g_bad_filter
        $error("ccg_clock_ctrl: filter lengths must be at least 1");
    end

    // -------------------------------------------------------------------
    // reset release synchroniser
    // -------------------------------------------------------------------
    logic rst_meta_q;   // first stage
    logic rst_n;        // released copy used everywhere

    // release through two flops so every register leaves reset on the same edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_raw;      // raw pins
    logic [PIN_COUNT-1:0] pin_meta_q;   // first stage, read only by second
    logic [PIN_COUNT-1:0] pin_q;        // synchronised pins

    assign pin_raw = {source_select, reset_input_n, start, speed_select,
                      stop_status_line, status_bit_one, status_bit_zero};

    // two flops on every pin before any logic looks at it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= PIN_RESET;
            pin_q      <= PIN_RESET;
        end else begin
            pin_meta_q <= pin_raw;
            pin_q      <= pin_meta_q;
        end
    end

    logic       restart_cmd;    // start high or reset pin low
    logic       xtal_mode;      // crystal source selected
    logic [2:0] status_now;     // {stop line, bit one, bit zero}

    assign restart_cmd = pin_q[PIN_START] | ~pin_q[PIN_RESN];
    assign xtal_mode   = ~pin_q[PIN_XSEL];
    assign status_now  = {pin_q[PIN_STOP], pin_q[PIN_S1], pin_q[PIN_S0]};

    // -------------------------------------------------------------------
    // speed select filters
    // -------------------------------------------------------------------
    logic slow_hit;     // low long enough
    logic fast_hit;     // high long enough

    // slow needs a long low run so glitches cannot slow the cpu
    ccg_level_filter #(
        .COUNT (SLOW_PULSES),
        .LEVEL (1'b0)
    ) u_slow_filter (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (pin_q[PIN_SPEED]),
        .hit      (slow_hit)
    );

    // fast needs only a short high run
    ccg_level_filter #(
        .COUNT (FAST_PULSES),
        .LEVEL (1'b1)
    ) u_fast_filter (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (pin_q[PIN_SPEED]),
        .hit      (fast_hit)
    );

    // -------------------------------------------------------------------
    // state and counters
    // -------------------------------------------------------------------
    ccg_state_e  state_q;       // stop / run state
    logic [9:0]  cnt_q;         // position in the cpu period
    logic [1:0]  pdiv_q;        // peripheral half-period counter
    logic        pclk_q;        // peripheral clock level
    logic [1:0]  drain_q;       // cpu periods completed since stop recognised
    logic [15:0] warm_q;        // restart delay counter
    logic [2:0]  hist_q;        // previous status sample
    logic        hist_ok_q;     // history holds a sample taken since restart
    logic        want_fast_q;   // recognised speed request
    logic        fast_q;        // speed in effect

    logic [9:0]  period;        // cpu period length for the current speed
    logic [9:0]  cpu_low;       // low part of the cpu clock
    logic [9:0]  half_low;      // low part of the half-duty clock
    logic        at_last;       // at the final (high) count of the period
    logic        advance;       // clocks move on this edge
    logic        wrap;          // cpu period ends on this edge
    logic        rise_ev;       // cpu clock rises on this edge
    logic        pedge;         // peripheral clock toggles on this edge
    logic        halt_seen;     // halt pattern after passive pattern
    logic [9:0]  cnt_d;         // next period position

    // divide ratio follows the speed in effect
    assign period   = fast_q ? FAST_PERIOD   : SLOW_PERIOD;
    assign cpu_low  = fast_q ? FAST_CPU_LOW  : SLOW_CPU_LOW;
    assign half_low = fast_q ? FAST_HALF_LOW : SLOW_HALF_LOW;
    assign at_last  = (cnt_q == period - 10'h001);

    // clocks freeze only while stopped, warming up or at the end of the drain
    assign advance = (state_q == CCG_RUN) ||
                     (state_q == CCG_DRAIN && !(drain_q == DRAIN_CYCLES && at_last));
    assign wrap    = advance && at_last;
    assign rise_ev = advance && (cnt_q == cpu_low - 10'h001);
    assign pedge   = advance && (pdiv_q == PCLK_HALF);
    assign cnt_d   = !advance ? cnt_q : (at_last ? 10'h000 : cnt_q + 10'h001);

    // same decode whatever the speed; a held restart suppresses it
    assign halt_seen = rise_ev && hist_ok_q && !restart_cmd &&
                       (hist_q == STATUS_PASSIVE) && (status_now == STATUS_HALT);

    // -------------------------------------------------------------------
    // stop / run state machine
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CCG_WARMUP;
            warm_q  <= '0;
            drain_q <= '0;
        end else begin
            unique case (state_q)
                CCG_WARMUP: begin
                    // crystal must settle before the clocks resume
                    if (!xtal_mode || warm_q == 16'(WARM_CYCLES - 1)) begin
                        state_q <= CCG_RUN;
                        warm_q  <= '0;
                    end else begin
                        warm_q  <= warm_q + 16'h0001;
                    end
                end
                CCG_RUN: begin
                    if (halt_seen) begin
                        state_q <= CCG_DRAIN;
                        drain_q <= '0;
                    end
                end
                CCG_DRAIN: begin
                    if (restart_cmd) begin
                        state_q <= CCG_RUN;                // start cancels a pending stop
                    end else if (drain_q == DRAIN_CYCLES && at_last) begin
                        state_q <= CCG_STOPPED;            // hold high after two cycles
                    end else if (wrap) begin
                        drain_q <= drain_q + 2'h1;
                    end
                end
                CCG_STOPPED: begin
                    // start wins even with the stop line still low
                    if (restart_cmd) begin
                        state_q <= xtal_mode ? CCG_WARMUP : CCG_RUN;
                        warm_q  <= '0;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // status history, sampled on cpu clock rises
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q    <= '0;
            hist_ok_q <= 1'b0;
        end else if (restart_cmd) begin
            // forget history so a fresh 111 then 011 is needed
            hist_q    <= '0;
            hist_ok_q <= 1'b0;
        end else if (rise_ev) begin
            hist_q    <= status_now;
            hist_ok_q <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // speed selection
    // -------------------------------------------------------------------
    // request flag follows the filters; restart with select high forces fast
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            want_fast_q <= 1'b1;
        end else if (restart_cmd && pin_q[PIN_SPEED]) begin
            want_fast_q <= 1'b1;
        end else if (fast_hit) begin
            want_fast_q <= 1'b1;
        end else if (slow_hit) begin
            want_fast_q <= 1'b0;
        end
    end

    // the ratio changes only where a peripheral edge meets a cpu period end,
    // so both cpu clocks keep their phase and no short pulse appears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_q <= 1'b1;
        end else if (wrap && pedge) begin
            fast_q <= want_fast_q;
        end
    end

    // -------------------------------------------------------------------
    // cpu period counter and cpu clocks
    // -------------------------------------------------------------------
    // both clocks fall together at count zero; frozen counter holds them high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q           <= FAST_PERIOD - 10'h001;
            cpu_clock       <= 1'b1;
            half_duty_clock <= 1'b1;
        end else begin
            cnt_q           <= cnt_d;
            cpu_clock       <= (cnt_d >= cpu_low);
            half_duty_clock <= (cnt_d >= half_low);
        end
    end

    // -------------------------------------------------------------------
    // peripheral clock, source divided by 6
    // -------------------------------------------------------------------
    // speed never enters here; a stop freezes whatever level it has
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pdiv_q <= PCLK_HALF;
            pclk_q <= 1'b1;
        end else if (advance) begin
            pdiv_q <= pedge ? 2'h0 : pdiv_q + 2'h1;
            if (pedge) begin
                pclk_q <= ~pclk_q;
            end
        end
    end

    assign peripheral_clock = pclk_q;

    // -------------------------------------------------------------------
    // oscillator and source gating
    // -------------------------------------------------------------------
    // crystal mode stops the oscillator; external mode only gates the source.
    // slow mode never touches the oscillator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oscillator_run <= 1'b1;
            source_gated   <= 1'b0;
            clocks_stopped <= 1'b0;
            fast_mode      <= 1'b1;
        end else begin
            oscillator_run <= !(state_q == CCG_STOPPED && xtal_mode);
            source_gated   <= (state_q == CCG_STOPPED) && !xtal_mode;
            clocks_stopped <= (state_q == CCG_STOPPED);
            fast_mode      <= fast_q;
        end
    end

    // the far side must raise the stop line for a cpu cycle before lowering it;
    // the history check above depends on that

endmodule : ccg_clock_ctrl

`default_nettype wire

// ### hdl/ccg_level_filter.sv
// Purpose: counts consecutive clock pulses at one level of an input
// Assumes: input already synchronised to clk
// Notes:   hit is a one-cycle pulse when the run length reaches COUNT
`timescale 1ns/100ps
`default_nettype none

module ccg_level_filter #(
    parameter int unsigned COUNT = 6,       // pulses the level must stand
    parameter bit          LEVEL = 1'b1     // level being watched
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // watched input
    input  wire logic level_in,
    // result
    output logic      hit
);

    localparam int unsigned W = $clog2(COUNT + 1);

    // -------------------------------------------------------------------
    // elaboration check
    // -------------------------------------------------------------------
    if (COUNT < 1) begin : g_bad_count
        $error("ccg_level_filter: COUNT must be at least 1");
    end

    logic [W-1:0] run_q;    // pulses seen at the watched level
    logic         prev_q;   // level on the previous pulse

    // run counter restarts whenever the input changes level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q  <= '0;
            prev_q <= ~LEVEL;
        end else begin
            prev_q <= level_in;
            if (level_in != LEVEL || prev_q != level_in) begin
                // a change (or the wrong level) starts the run over
                run_q <= (level_in == LEVEL) ? W'(1) : '0;
            end else if (run_q != W'(COUNT)) begin
                run_q <= run_q + W'(1);
            end
        end
    end

    // single pulse when the run first reaches its length
    assign hit = (level_in == LEVEL) && (prev_q == level_in) && (run_q == W'(COUNT - 1));

endmodule : ccg_level_filter

`default_nettype wire

// ### hdl/ccg_pkg.sv
// Purpose: shared constants of the clock stop / slow-fast controller
// Assumes: one source clock edge of clk stands for one oscillator or external frequency pulse
// Notes:   status patterns are ordered {stop_status_line, status_bit_one, status_bit_zero}

package ccg_pkg;

    // ------------------------------------------------------------------
    // divider shapes, in source pulses
    // ------------------------------------------------------------------
    localparam logic [9:0] FAST_PERIOD   = 10'h003;   // divide by 3
    localparam logic [9:0] SLOW_PERIOD   = 10'h300;   // divide by 768
    localparam logic [9:0] FAST_CPU_LOW  = 10'h002;   // 33 percent high
    localparam logic [9:0] SLOW_CPU_LOW  = 10'h200;
    localparam logic [9:0] FAST_HALF_LOW = 10'h001;   // nearest to 50 percent at 3
    localparam logic [9:0] SLOW_HALF_LOW = 10'h180;
    localparam logic [1:0] PCLK_HALF     = 2'h2;      // toggle every 3 pulses
    localparam logic [1:0] DRAIN_CYCLES  = 2'h2;      // further cpu cycles before hold

    // ------------------------------------------------------------------
    // speed filter lengths and restart delay
    // ------------------------------------------------------------------
    localparam int unsigned SLOW_FILTER_PULSES = 195;
    localparam int unsigned FAST_FILTER_PULSES = 6;
    localparam int unsigned WARMUP_PULSES      = 8192;

    // ------------------------------------------------------------------
    // status patterns {stop line, bit one, bit zero}
    // ------------------------------------------------------------------
    localparam logic [2:0] STATUS_PASSIVE = 3'h7;     // 111
    localparam logic [2:0] STATUS_HALT    = 3'h3;     // 011

    // ------------------------------------------------------------------
    // pin synchroniser layout
    // ------------------------------------------------------------------
    localparam int unsigned PIN_S0    = 0;
    localparam int unsigned PIN_S1    = 1;
    localparam int unsigned PIN_STOP  = 2;
    localparam int unsigned PIN_SPEED = 3;
    localparam int unsigned PIN_START = 4;
    localparam int unsigned PIN_RESN  = 5;
    localparam int unsigned PIN_XSEL  = 6;
    localparam int unsigned PIN_COUNT = 7;
    localparam logic [6:0]  PIN_RESET = 7'h27;        // idle pin levels at reset

    // controller states
    typedef enum logic [1:0] {
        CCG_WARMUP,
        CCG_RUN,
        CCG_DRAIN,
        CCG_STOPPED
    } ccg_state_e;

endpackage : ccg_pkg

// ### sim/ccg_clock_ctrl_checker.sv
// Purpose: port-level checks of the clock stop / slow-fast controller
// Assumes: SLOW_PULSES equals the value given to the design instance
// Notes:   long runs are counted in helper registers, not repetitions
`timescale 1ns/100ps
`default_nettype none
module ccg_clock_ctrl_checker #(
    parameter int unsigned SLOW_PULSES = 195  // slow request filter length
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins that cause effects
    input wire logic speed_select,
    input wire logic start,
    input wire logic source_select,
    // watched outputs
    input wire logic cpu_clock,
    input wire logic half_duty_clock,
    input wire logic peripheral_clock,
    input wire logic oscillator_run,
    input wire logic source_gated,
    input wire logic clocks_stopped,
    input wire logic fast_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [15:0] low_q;  // samples the speed pin has stayed low
    logic [15:0] hi_q;   // samples the cpu clock has stayed high
    // run counters; stretches never reach the 16-bit wrap in use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_q <= 16'h0000;
            hi_q  <= 16'h0000;
        end else begin
            low_q <= speed_select ? 16'h0000 : low_q + 16'h0001;
            hi_q  <= cpu_clock ? hi_q + 16'h0001 : 16'h0000;
        end
    end
    sequence s_fast_pulse;  // one-sample high pulse while fast
        $rose(cpu_clock) && fast_mode ##1 !cpu_clock && fast_mode;
    endsequence
    sequence s_frozen;  // both cpu clocks parked high
        cpu_clock && half_duty_clock;
    endsequence
    property p_fast_shape;  // a switch to slow may end the train
        s_fast_pulse |=> !cpu_clock ##1 (cpu_clock || !fast_mode);
    endproperty
    a_fast_shape: assert property (p_fast_shape) else $error("fast cpu clock shape wrong");
    property p_slow_high;  // 256 earlier high samples before the fall
        $fell(cpu_clock) && !fast_mode && !$past(fast_mode, 2) |-> hi_q >= 16'h0100;
    endproperty
    a_slow_high: assert property (p_slow_high) else $error("slow cpu high phase short");
    property p_half_with_cpu;
        $fell(cpu_clock) |-> $fell(half_duty_clock);
    endproperty
    a_half_with_cpu: assert property (p_half_with_cpu) else $error("clocks fell apart");
    property p_pclk_width;
        $changed(peripheral_clock) |=> $stable(peripheral_clock) [*2];
    endproperty
    a_pclk_width: assert property (p_pclk_width) else $error("peripheral clock phase short");
    property p_freeze_high;
        clocks_stopped |-> s_frozen;
    endproperty
    a_freeze_high: assert property (p_freeze_high) else $error("stopped clocks not high");
    property p_pclk_frozen;
        clocks_stopped [*2] |-> $stable(peripheral_clock);
    endproperty
    a_pclk_frozen: assert property (p_pclk_frozen) else $error("peripheral clock moved");
    property p_stop_source;
        clocks_stopped |-> oscillator_run == source_select && source_gated == source_select;
    endproperty
    a_stop_source: assert property (p_stop_source) else $error("wrong source stopped");
    property p_run_source;
        !clocks_stopped |-> oscillator_run && !source_gated;
    endproperty
    a_run_source: assert property (p_run_source) else $error("source off while running");
    property p_start_wins;
        start [*8] |-> !clocks_stopped;
    endproperty
    a_start_wins: assert property (p_start_wins) else $error("still stopped under start");
    property p_slow_filter;
        $fell(fast_mode) |-> low_q >= SLOW_PULSES;
    endproperty
    a_slow_filter: assert property (p_slow_filter) else $error("slow taken too early");
    property p_ratio_at_pclk;
        $changed(fast_mode) |-> $past(peripheral_clock) != $past(peripheral_clock, 2)
            || peripheral_clock != $past(peripheral_clock);
    endproperty
    a_ratio_at_pclk: assert property (p_ratio_at_pclk) else $error("ratio change off edge");
endmodule : ccg_clock_ctrl_checker
`default_nettype wire

// ### sim/ccg_status_port.sv
// Purpose: model of the output port line feeding the status pins
// Assumes: driven from the bench clock's falling edge
// Notes:   the stop line rests low, as with a pull-down bias
`timescale 1ns/100ps
`default_nettype none
module ccg_status_port (
    // clocks seen by the port
    input  wire logic clk,
    input  wire logic cpu_clock,
    // status pins
    output logic      status_bit_zero,
    output logic      status_bit_one,
    output logic      stop_status_line
);
    // low stop line at power-up keeps a halt from being armed
    initial {stop_status_line, status_bit_one, status_bit_zero} = 3'h3;
    // drive one pattern {stop, bit one, bit zero}
    task automatic put(input logic [2:0] p);
        @(negedge clk);
        {stop_status_line, status_bit_one, status_bit_zero} = p;
    endtask : put
    // passive first, held over a full cpu cycle, then halt
    task automatic halt_seq();
        put(3'h7);
        repeat (2) @(posedge cpu_clock);
        put(3'h3);
    endtask : halt_seq
endmodule : ccg_status_port
`default_nettype wire

// ### sim/test_clock_stop_slow_fast_control.sv
// Purpose: self-checking bench of the clock stop / slow-fast controller
// Assumes: warm-up shortened to 16 and slow filter to 8 pulses
// Notes:   random status noise never holds the halt pattern
`timescale 1ns/100ps
`default_nettype none
module test_clock_stop_slow_fast_control;
    logic clk = 1'b0, resetn = 1'b0, speed_select = 1'b1, start = 1'b0;
    logic reset_input_n = 1'b1, source_select = 1'b0, s0, s1, stop_line, q;
    logic cpu_clock, half_duty_clock, peripheral_clock, oscillator_run;
    logic source_gated, clocks_stopped, fast_mode;
    logic [31:0] rng = 32'h0000_1643;  // seed 5699
    int failures = 0, checks_done = 0, n;
    always #5 clk = ~clk;
    ccg_clock_ctrl #(.WARM_CYCLES(16), .SLOW_PULSES(8), .FAST_PULSES(6)) dut_u (
        .clk(clk), .resetn(resetn), .status_bit_zero(s0), .status_bit_one(s1),
        .stop_status_line(stop_line), .speed_select(speed_select), .start(start),
        .reset_input_n(reset_input_n), .source_select(source_select),
        .cpu_clock(cpu_clock), .half_duty_clock(half_duty_clock),
        .peripheral_clock(peripheral_clock), .oscillator_run(oscillator_run),
        .source_gated(source_gated), .clocks_stopped(clocks_stopped), .fast_mode(fast_mode));
    ccg_status_port part_u (.clk(clk), .cpu_clock(cpu_clock), .status_bit_zero(s0),
        .status_bit_one(s1), .stop_status_line(stop_line));
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd
    task automatic test_done();
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk_bit
    task automatic chk_num(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp) begin
            failures++;
            $display("mismatch at %0t: %s got %0d", $time, what, got);
        end
    endtask : chk_num
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // negedges until the next rise of the cpu (0) or peripheral (1) clock
    task automatic wait_rise(input bit p, output int k);
        logic prev;
        k = 0;
        prev = 1'b1;
        while (!((p ? peripheral_clock : cpu_clock) === 1'b1 && prev === 1'b0) && k < 2000) begin
            prev = p ? peripheral_clock : cpu_clock;
            @(negedge clk);
            k++;
        end
    endtask : wait_rise
    // bounded wait on stopped (0) or fast mode (1), then compare
    task automatic await(input bit s, input logic exp);
        int k;
        for (k = 0; k < 4000 && (s ? fast_mode : clocks_stopped) !== exp; k++) @(negedge clk);
        chk_bit(s ? fast_mode : clocks_stopped, exp, "flag did not settle");
    endtask : await
    initial begin
        #500_000;
        failures++;
        test_done();
    end
    initial begin
        cyc(4);
        chk_bit(fast_mode, 1'b1, "reset speed");
        resetn = 1'b1;
        // random status traffic that never shows the halt pattern
        repeat (40) begin
            q = 1'b0;
            n = int'(rnd() % 8);
            if (n != 3) part_u.put(n[2:0]);
        end
        chk_bit(clocks_stopped, 1'b0, "stopped by noise");
        wait_rise(1'b0, n);
        wait_rise(1'b0, n);
        chk_num(n, 3, "fast cpu period");
        wait_rise(1'b1, n);
        wait_rise(1'b1, n);
        chk_num(n, 6, "pclk period");
        // halt in crystal mode
        part_u.halt_seq();
        await(1'b0, 1'b1);
        chk_bit(oscillator_run, 1'b0, "oscillator kept");
        chk_bit(half_duty_clock, 1'b1, "half clock level");
        q = peripheral_clock;
        cyc(30);
        chk_bit(peripheral_clock, q, "pclk moved");
        // start while the stop line stays low
        start = 1'b1;
        await(1'b0, 1'b0);
        start = 1'b0;
        wait_rise(1'b0, n);
        chk_bit(n >= 16 && n < 2000, 1'b1, "warm-up too short");
        cyc(200);
        chk_bit(clocks_stopped, 1'b0, "stale halt taken");
        // halt with the external source
        source_select = 1'b1;
        cyc(10);
        part_u.halt_seq();
        await(1'b0, 1'b1);
        chk_bit(source_gated, 1'b1, "source not gated");
        part_u.put(3'h7);
        reset_input_n = 1'b0;
        await(1'b0, 1'b0);
        part_u.put(3'h3);
        reset_input_n = 1'b1;
        // short random low glitches on the speed pin
        repeat (6) begin
            speed_select = 1'b0;
            cyc(1 + int'(rnd() % 4));
            speed_select = 1'b1;
            cyc(6);
        end
        chk_bit(fast_mode, 1'b1, "glitch took slow");
        chk_bit(clocks_stopped, 1'b0, "stale halt taken");
        speed_select = 1'b0;
        await(1'b1, 1'b0);
        wait_rise(1'b0, n);
        wait_rise(1'b0, n);
        chk_num(n, 768, "slow cpu period");
        wait_rise(1'b1, n);
        wait_rise(1'b1, n);
        chk_num(n, 6, "slow pclk period");
        speed_select = 1'b1;
        cyc(1 + int'(rnd() % 3));
        speed_select = 1'b0;
        cyc(800);
        chk_bit(fast_mode, 1'b0, "glitch took fast");
        // halt while slow
        part_u.halt_seq();
        await(1'b0, 1'b1);
        chk_bit(cpu_clock, 1'b1, "slow stop level");
        start = 1'b1;
        await(1'b0, 1'b0);
        cyc(8);
        start = 1'b0;
        speed_select = 1'b1;
        await(1'b1, 1'b1);
        test_done();
    end
endmodule : test_clock_stop_slow_fast_control
bind ccg_clock_ctrl ccg_clock_ctrl_checker #(.SLOW_PULSES(SLOW_PULSES)) chk_u (
    .clk(clk), .resetn(resetn), .speed_select(speed_select), .start(start),
    .source_select(source_select), .cpu_clock(cpu_clock), .half_duty_clock(half_duty_clock),
    .peripheral_clock(peripheral_clock), .oscillator_run(oscillator_run),
    .source_gated(source_gated), .clocks_stopped(clocks_stopped), .fast_mode(fast_mode));
`default_nettype wire
